// File: ssmc_chk_sva.sv
// Purpose: port assertions for the supply mode controller
// Assumes: one clock, synchronous active low reset
// Notes: cascade order is judged from sequence positions
`default_nettype none
`include "ssmc_map.vh"
module ssmc_chk
(
	input wire logic CLOCK_I, // Core clock
	input wire logic NRST_I, // Reset, active low
	input wire logic FORCED_OFF_LINE_N_I, // Forced-off level
	input wire logic POWER_UP_REQUEST_OE_O, // Request pull-down
	input wire logic [7:0] SEQ_ORDER_I, // Positions
	input wire logic [3:0] ENABLE_POL_I, // Enable levels
	input wire logic [3:0] CH_USED_I, // Channels used
	input wire logic [3:0] SEQ_THR_I, // Above threshold
	input wire logic [3:0] SUPPLY_OFF_I, // Fallen off
	input wire logic [7:0] MARGIN_SET_I, // Margin targets
	input wire logic MARGIN_EXIT_I, // Leave margin pulse
	input wire logic [3:0] CONVERTER_ENABLE_O, // Enables
	input wire logic [3:0] REG_ACTIVE_O, // Regulation
	input wire logic [7:0] REG_TARGET_O, // Targets
	input wire logic SUPPLIES_GOOD_O, // Good
	input wire logic RESET_N_O, // Reset
	input wire logic [2:0] MODE_O // Mode
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] on, prior_ok, later_off; // Active enables, cascade gates
	// Gates from the positions of used channels
	always_comb
	begin
		for (int g = 0; g < 4; g++)
		begin
			on[g] = CONVERTER_ENABLE_O[g] == ENABLE_POL_I[g];
			prior_ok[g] = 1'b1;
			later_off[g] = 1'b1;
			for (int h = 0; h < 4; h++)
			begin
				// Earlier positions up, later positions down
				if (CH_USED_I[h] && SEQ_ORDER_I[2*h+:2] < SEQ_ORDER_I[2*g+:2])
					prior_ok[g] &= SEQ_THR_I[h];
				if (CH_USED_I[h] && SEQ_ORDER_I[2*h+:2] > SEQ_ORDER_I[2*g+:2])
					later_off[g] &= SUPPLY_OFF_I[h];
			end
		end
	end
	default clocking @(posedge CLOCK_I);
	endclocking
	default disable iff (!NRST_I);
	pon_cascade_a: assert property
		((on & ~$past(on) & CH_USED_I & ~$past(prior_ok)) == 4'h0)
		else $error("Enable rose before earlier supply was up");
	poff_cascade_a: assert property
		(MODE_O == `SSMC_MD_POFF |-> (~on & $past(on) & CH_USED_I & ~$past(later_off)) == 4'h0)
		else $error("Enable fell before later supplies were off");
	pon_outputs_a: assert property
		(MODE_O == `SSMC_MD_PON |-> !SUPPLIES_GOOD_O && !RESET_N_O)
		else $error("Good or reset wrong during power-on");
	marg_outputs_a: assert property
		(MODE_O == `SSMC_MD_MARG && $past(MODE_O) == `SSMC_MD_MARG |-> SUPPLIES_GOOD_O && RESET_N_O)
		else $error("Good or reset wrong while margining");
	marg_entry_a: assert property
		(MODE_O == `SSMC_MD_MARG && $past(MODE_O) != `SSMC_MD_MARG |-> $past(MODE_O) == `SSMC_MD_MON)
		else $error("Margin entered from a mode other than monitor");
	poff_entry_a: assert property
		(MODE_O == `SSMC_MD_POFF && $past(MODE_O) != `SSMC_MD_POFF |-> $past(MODE_O) == `SSMC_MD_MON)
		else $error("Power-off entered from a mode other than monitor");
	marg_target_a: assert property
		(MODE_O == `SSMC_MD_MARG && !$past(MARGIN_EXIT_I)
		|-> REG_TARGET_O == $past(MARGIN_SET_I))
		else $error("Margin targets not applied");
	poff_regoff_a: assert property
		(MODE_O == `SSMC_MD_POFF && $past(MODE_O) == `SSMC_MD_POFF |-> REG_ACTIVE_O == 4'h0)
		else $error("Regulation still active in power-off");
	foff_kill_a: assert property
		($fell(FORCED_OFF_LINE_N_I) ##0 (!FORCED_OFF_LINE_N_I)[*8]
		|-> on == 4'h0 && POWER_UP_REQUEST_OE_O)
		else $error("Forced-off did not clear enables and pull request");
endmodule
bind ssmc_top ssmc_chk u_chk
(
	.CLOCK_I, .NRST_I, .FORCED_OFF_LINE_N_I, .POWER_UP_REQUEST_OE_O, .SEQ_ORDER_I,
	.ENABLE_POL_I, .CH_USED_I, .SEQ_THR_I, .SUPPLY_OFF_I, .MARGIN_SET_I, .MARGIN_EXIT_I,
	.CONVERTER_ENABLE_O, .REG_ACTIVE_O, .REG_TARGET_O, .SUPPLIES_GOOD_O, .RESET_N_O, .MODE_O
);
`default_nettype wire

// File: ssmc_conv_model.sv
// Purpose: converter bank model with ramping outputs
// Assumes: enables read through their active level
// Notes: DLY sets how slowly supplies rise and fall
`default_nettype none
module ssmc_conv_model #(parameter int DLY = 8)
(
	input wire logic clk_i, // Core clock
	input wire logic [3:0] en_i, // Enable pins
	input wire logic [3:0] pol_i, // Enable active level
	output logic [3:0] thr_o, // Above threshold
	output logic [3:0] off_o // Fully off
);
	timeunit 1ns;
	timeprecision 1ps;
	int lvl [4] = '{default: 0}; // Ramp step per supply
	// Ramp up while enabled, decay otherwise
	always @(posedge clk_i)
	begin
		for (int g = 0; g < 4; g++)
			if (en_i[g] === pol_i[g])
				lvl[g] <= (lvl[g] < DLY) ? lvl[g] + 1 : DLY;
			else
				lvl[g] <= (lvl[g] > 0) ? lvl[g] - 1 : 0;
	end
	always_comb
	begin
		for (int g = 0; g < 4; g++)
		begin
			thr_o[g] = lvl[g] == DLY;
			off_o[g] = lvl[g] == 0;
		end
	end
endmodule
`default_nettype wire

// File: ssmc_map.vh
// Purpose: constants for the supply sequence mode controller
// Assumes: 100 MHz core clock
// Notes: times are given in microseconds, counts derive from them
`ifndef SSMC_MAP_VH
`define SSMC_MAP_VH
`define SSMC_CLK_MHZ 100
`define SSMC_NCH 4
`define SSMC_NMON 9
`define SSMC_SCAN_US 2000
`define SSMC_SCAN_CYC ((`SSMC_SCAN_US * `SSMC_CLK_MHZ) / `SSMC_NMON)
`define SSMC_RTO0_US 640
`define SSMC_RTO1_US 25000
`define SSMC_RTO2_US 100000
`define SSMC_RTO3_US 200000
`define SSMC_RTO0_CYC (25'd`SSMC_RTO0_US * 25'd`SSMC_CLK_MHZ)
`define SSMC_RTO1_CYC (25'd`SSMC_RTO1_US * 25'd`SSMC_CLK_MHZ)
`define SSMC_RTO2_CYC (25'd`SSMC_RTO2_US * 25'd`SSMC_CLK_MHZ)
`define SSMC_RTO3_CYC (25'd`SSMC_RTO3_US * 25'd`SSMC_CLK_MHZ)
`define SSMC_MD_IDLE 3'h0
`define SSMC_MD_PON 3'h1
`define SSMC_MD_SETTLE 3'h2
`define SSMC_MD_MON 3'h3
`define SSMC_MD_MARG 3'h4
`define SSMC_MD_POFF 3'h5
`define SSMC_MARG_NOM 2'h0
`define SSMC_MARG_HI 2'h1
`define SSMC_MARG_LO 2'h2
`endif

// File: ssmc_sync.v
// Purpose: three stage pin synchroniser with agreement filter
// Assumes: input is asynchronous to CLOCK_I
// Notes: output changes once stages two and three agree
`default_nettype none
module ssmc_sync
(
	input wire clk_i, // Core clock
	input wire nrst_i, // Synchronous reset, active low
	input wire rst_val_i, // Value held during reset
	input wire din_i, // Asynchronous pin level
	output reg dout_o // Filtered level
);
	reg s1; // First stage, read only by s2
	reg s2; // Second stage
	reg s3; // Third stage
	// Shift and accept on agreement
	always @(posedge clk_i)
	begin
		if (!nrst_i)
		begin
			s1 <= rst_val_i;
			s2 <= rst_val_i;
			s3 <= rst_val_i;
			dout_o <= rst_val_i;
		end
		else
		begin
			s1 <= din_i;
			s2 <= s1;
			s3 <= s2;
			if (s2 == s3)
				dout_o <= s3;
		end
	end
endmodule
`default_nettype wire

// File: ssmc_top.v
// Purpose: mode controller of a four channel supply sequencer
// Assumes: limit flags arrive synchronous, one per scan slot
// Notes: analog regulation and host framing live outside
`default_nettype none
`include "ssmc_map.vh"
module ssmc_top
(
	input wire CLOCK_I, // Core clock, 100 MHz
	input wire NRST_I, // Synchronous reset, active low
	input wire POWER_UP_REQUEST_I, // Request pin level
	output reg POWER_UP_REQUEST_O, // Request pin drive low
	output reg POWER_UP_REQUEST_OE_O, // Request pin drive enable
	input wire FORCED_OFF_LINE_N_I, // Forced-off pin level
	output reg FORCED_OFF_LINE_N_O, // Forced-off pin drive low
	output reg FORCED_OFF_LINE_N_OE_O, // Forced-off pin drive enable
	input wire CHAIN_LINE_I, // Chain line level from peers
	output reg CHAIN_LINE_O, // Chain line drive low
	output reg CHAIN_LINE_OE_O, // Chain line drive enable
	input wire MANUAL_RESET_N_I, // Manual reset pin, active low
	input wire [7:0] SEQ_ORDER_I, // Slot per channel, 2 bits each
	input wire [3:0] ENABLE_POL_I, // Enable active level per channel
	input wire [3:0] CH_USED_I, // Channel takes part in sequence
	input wire [15:0] TERM_TIMEOUT_I, // Stall limit in scan periods
	input wire TERM_ON_EN_I, // Termination timer on power-on
	input wire TERM_OFF_EN_I, // Termination timer on power-off
	input wire REGULATION_EN_I, // Output regulation enabled
	input wire [1:0] RESET_TIMEOUT_SEL_I, // Reset release delay select
	input wire [8:0] UV1_I, // Under limit one crossed, per input
	input wire [8:0] UV2_I, // Under limit two crossed, per input
	input wire [8:0] OV1_I, // Over limit one crossed, per input
	input wire [8:0] OV2_I, // Over limit two crossed, per input
	input wire [3:0] SEQ_THR_I, // Supply above sequence threshold
	input wire [3:0] SUPPLY_OFF_I, // Supply has fallen off
	input wire [8:0] TRIG_RESET_I, // Input faults drive reset
	input wire [8:0] TRIG_GOOD_I, // Input counted for good
	input wire [8:0] TRIG_ALARM_I, // Input faults drive alarm
	input wire [8:0] TRIG_POFF_I, // Input faults start power-off
	input wire [8:0] TRIG_FOFF_I, // Input faults force shutdown
	input wire MARGIN_CMD_I, // Host margin request pulse
	input wire MARGIN_EXIT_I, // Host leave margin pulse
	input wire [7:0] MARGIN_SET_I, // Target per supply, 2 bits each
	input wire POWER_OFF_CMD_I, // Host power-off pulse
	input wire [3:0] CONV_SEL_I, // Selected single channel
	input wire CONV_REQ_I, // Single conversion request pulse
	input wire [9:0] CONV_DATA_I, // Converter result for slot
	output reg [3:0] CONVERTER_ENABLE_O, // Enable outputs, polarity applied
	output reg [3:0] SCAN_SLOT_O, // Channel the converter visits
	output reg [3:0] REG_ACTIVE_O, // Regulation per supply
	output reg [7:0] REG_TARGET_O, // Target per supply
	output reg SUPPLIES_GOOD_O, // All good, active high
	output reg RESET_N_O, // Reset, active low
	output reg ALARM_N_O, // Alarm, active low
	output reg [2:0] MODE_O, // Current operating mode
	output reg [9:0] CONV_RESULT_O, // Single conversion result
	output reg CONV_DONE_O // Result valid, level until next request
);
	// Synchronised pins
	wire req_s; // Request pin level
	wire foff_n_s; // Forced-off level
	wire mr_n_s; // Manual reset level
	wire chain_s; // Chain level
	ssmc_sync u_req (.clk_i(CLOCK_I), .nrst_i(NRST_I), .rst_val_i(1'b1),
		.din_i(POWER_UP_REQUEST_I), .dout_o(req_s));
	ssmc_sync u_foff (.clk_i(CLOCK_I), .nrst_i(NRST_I), .rst_val_i(1'b1),
		.din_i(FORCED_OFF_LINE_N_I), .dout_o(foff_n_s));
	ssmc_sync u_mr (.clk_i(CLOCK_I), .nrst_i(NRST_I), .rst_val_i(1'b1),
		.din_i(MANUAL_RESET_N_I), .dout_o(mr_n_s));
	ssmc_sync u_chain (.clk_i(CLOCK_I), .nrst_i(NRST_I), .rst_val_i(1'b1),
		.din_i(CHAIN_LINE_I), .dout_o(chain_s));

	reg [2:0] mode; // Operating mode
	reg req_d; // Previous request level
	reg [3:0] en; // Logical enables
	reg [1:0] step; // Current sequence position
	reg [15:0] scan_cnt; // Cycles within scan slot
	reg [3:0] slot; // Current scan slot
	reg [15:0] stall_cnt; // Scan periods without progress
	reg [8:0] fault; // Latched per-input fault flags
	reg [24:0] rto_cnt; // Reset release counter
	reg pulse_foff; // Own forced-off drive request
	wire [3:0] in_step; // Channels in current position
	wire [3:0] step_thr_ok; // Per channel threshold met
	wire [3:0] step_off_ok; // Per channel fallen off
	wire slot_end; // Last cycle of a scan slot
	wire period_end; // Last cycle of nine slots
	wire req_rise; // Request pin rising
	wire req_fall; // Request pin falling
	wire fault_poff; // Fault starts power-off
	wire fault_foff; // Fault forces shutdown
	wire rst_src; // Any reset source active
	reg [24:0] rto_lim; // Selected reset delay in cycles

	// Per-channel decode of sequence position
	genvar g;
	generate
		for (g = 0; g < `SSMC_NCH; g = g + 1)
		begin : g_ch
			assign in_step[g] = CH_USED_I[g] && (SEQ_ORDER_I[2*g+1:2*g] == step);
			assign step_thr_ok[g] = !in_step[g] || SEQ_THR_I[g];
			assign step_off_ok[g] = !in_step[g] || SUPPLY_OFF_I[g];
		end
	endgenerate

	assign slot_end = (scan_cnt == `SSMC_SCAN_CYC - 1);
	assign period_end = slot_end && (slot == `SSMC_NMON - 1);
	assign req_rise = req_s && !req_d;
	assign req_fall = !req_s && req_d;
	assign fault_poff = |(fault & TRIG_POFF_I);
	assign fault_foff = |(fault & TRIG_FOFF_I);
	assign rst_src = !mr_n_s || (|(fault & TRIG_RESET_I)) || (mode != `SSMC_MD_MON);

	// Reset delay select
	always @*
	begin
		case (RESET_TIMEOUT_SEL_I)
			2'h0: rto_lim = `SSMC_RTO0_CYC;
			2'h1: rto_lim = `SSMC_RTO1_CYC;
			2'h2: rto_lim = `SSMC_RTO2_CYC;
			default: rto_lim = `SSMC_RTO3_CYC;
		endcase
	end

	// round-robin scan, flags sampled per slot
	always @(posedge CLOCK_I)
	begin
		if (!NRST_I)
		begin
			scan_cnt <= 16'h0;
			slot <= 4'h0;
			fault <= 9'h0;
		end
		else
		begin
			scan_cnt <= slot_end ? 16'h0 : scan_cnt + 16'h1;
			if (slot_end)
			begin
				// any of the four limits marks a fault
				fault[slot] <= UV1_I[slot] | UV2_I[slot] | OV1_I[slot] | OV2_I[slot];
				slot <= (slot == `SSMC_NMON - 1) ? 4'h0 : slot + 4'h1;
			end
		end
	end

	// Mode machine
	always @(posedge CLOCK_I)
	begin
		if (!NRST_I)
		begin
			mode <= `SSMC_MD_IDLE;
			req_d <= 1'b1;
			en <= 4'h0;
			step <= 2'h0;
			stall_cnt <= 16'h0;
			pulse_foff <= 1'b0;
			REG_ACTIVE_O <= 4'h0;
			REG_TARGET_O <= 8'h0;
		end
		else
		begin
			req_d <= req_s;
			pulse_foff <= 1'b0;
			if (period_end)
				stall_cnt <= stall_cnt + 16'h1;
			if (!foff_n_s)
			begin
				en <= 4'h0;
				REG_ACTIVE_O <= 4'h0;
				mode <= `SSMC_MD_IDLE;
			end
			else
			begin
				case (mode)
					`SSMC_MD_IDLE:
					begin
						if (req_rise)
						begin
							mode <= `SSMC_MD_PON;
							step <= 2'h0;
							stall_cnt <= 16'h0;
						end
					end
					`SSMC_MD_PON:
					begin
						en <= en | in_step;
						if (&step_thr_ok && ((en & in_step) == in_step))
						begin
							stall_cnt <= 16'h0;
							if (step == 2'h3)
								mode <= `SSMC_MD_SETTLE;
							else
								step <= step + 2'h1;
						end
						else if (TERM_ON_EN_I && stall_cnt >= TERM_TIMEOUT_I)
						begin
							en <= 4'h0;
							mode <= `SSMC_MD_IDLE;
						end
					end
					`SSMC_MD_SETTLE:
					begin
						// used supplies above under limit one, regulate to nominal
						if (!(|(UV1_I[3:0] & CH_USED_I)) && chain_s)
						begin
							REG_ACTIVE_O <= REGULATION_EN_I ? CH_USED_I : 4'h0;
							REG_TARGET_O <= 8'h0;
							mode <= `SSMC_MD_MON;
						end
					end
					`SSMC_MD_MON:
					begin
						// three power-off causes; only from here
						if (req_fall || POWER_OFF_CMD_I || fault_poff)
						begin
							REG_ACTIVE_O <= 4'h0;
							step <= 2'h3;
							stall_cnt <= 16'h0;
							mode <= `SSMC_MD_POFF;
						end
						else if (fault_foff)
							pulse_foff <= 1'b1;
						else if (MARGIN_CMD_I)
						begin
							REG_TARGET_O <= MARGIN_SET_I;
							mode <= `SSMC_MD_MARG;
						end
					end
					`SSMC_MD_MARG:
					begin
						REG_TARGET_O <= MARGIN_SET_I;
						if (MARGIN_EXIT_I)
						begin
							REG_TARGET_O <= 8'h0;
							mode <= `SSMC_MD_MON;
						end
					end
					`SSMC_MD_POFF:
					begin
						en <= en & ~in_step;
						if (&step_off_ok && ((en & in_step) == 4'h0))
						begin
							stall_cnt <= 16'h0;
							if (step == 2'h0)
								mode <= `SSMC_MD_IDLE;
							else
								step <= step - 2'h1;
						end
						else if (TERM_OFF_EN_I && stall_cnt >= TERM_TIMEOUT_I)
							pulse_foff <= 1'b1;
					end
					default:
						mode <= `SSMC_MD_IDLE;
				endcase
			end
		end
	end

	// Reset timeout counter
	always @(posedge CLOCK_I)
	begin
		if (!NRST_I)
			rto_cnt <= 25'h0;
		else if (rst_src)
			rto_cnt <= 25'h0;
		else if (rto_cnt < rto_lim)
			rto_cnt <= rto_cnt + 25'h1;
	end

	// Registered outputs
	always @(posedge CLOCK_I)
	begin
		if (!NRST_I)
		begin
			CONVERTER_ENABLE_O <= ~ENABLE_POL_I;
			SUPPLIES_GOOD_O <= 1'b0;
			RESET_N_O <= 1'b0;
			ALARM_N_O <= 1'b1;
			MODE_O <= `SSMC_MD_IDLE;
			SCAN_SLOT_O <= 4'h0;
			POWER_UP_REQUEST_O <= 1'b0;
			POWER_UP_REQUEST_OE_O <= 1'b0;
			FORCED_OFF_LINE_N_O <= 1'b0;
			FORCED_OFF_LINE_N_OE_O <= 1'b0;
			CHAIN_LINE_O <= 1'b0;
			CHAIN_LINE_OE_O <= 1'b0;
			CONV_RESULT_O <= 10'h0;
			CONV_DONE_O <= 1'b0;
		end
		else
		begin
			CONVERTER_ENABLE_O <= ~(en ^ ENABLE_POL_I);
			MODE_O <= mode;
			SCAN_SLOT_O <= CONV_REQ_I ? CONV_SEL_I : slot;
			ALARM_N_O <= !(|(fault & TRIG_ALARM_I));
			if (mode == `SSMC_MD_MARG)
			begin
				// margin forces good and released reset
				SUPPLIES_GOOD_O <= 1'b1;
				RESET_N_O <= 1'b1;
			end
			else
			begin
				// good only in monitor mode and in limits
				SUPPLIES_GOOD_O <= (mode == `SSMC_MD_MON) && !(|(fault & TRIG_GOOD_I));
				RESET_N_O <= !rst_src && (rto_cnt >= rto_lim);
			end
			// forced-off also pulls the request low
			POWER_UP_REQUEST_OE_O <= !foff_n_s || pulse_foff;
			FORCED_OFF_LINE_N_OE_O <= pulse_foff;
			// hold chain low until our sequence done
			CHAIN_LINE_OE_O <= (mode == `SSMC_MD_PON) || (mode == `SSMC_MD_POFF);
			if (CONV_REQ_I)
				CONV_DONE_O <= 1'b0;
			else if (slot_end && SCAN_SLOT_O == CONV_SEL_I)
			begin
				CONV_RESULT_O <= CONV_DATA_I;
				CONV_DONE_O <= 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// File: tb.sv
// Purpose: self-checking bench for the supply mode controller
// Assumes: converter model answers enables after a short ramp
// Notes: one power cycle, margin visit, forced-off abort
`default_nettype none
`include "ssmc_map.vh"
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0, nrst = 1'b0, req_host = 1'b0, foff_host = 1'b1; // Clock, reset, pins
	logic [2:0] cmd = 3'h0; // Pulses: power-off, exit, margin
	logic [7:0] order = 8'h1e, mset = 8'h00; // Positions 2,3,1,0; targets
	logic [3:0] pol = 4'h5, used = 4'hf; // Enable levels, channels used
	logic [8:0] flt = 9'h000, trg = 9'h1ff; // Limit flags, routing
	logic mr_n = 1'b1, reg_en = 1'b1, term_en = 1'b0; // Misc controls
	wire [3:0] en, thr, off, reg_act; // Enables and supply state
	wire [7:0] tgt; // Regulation targets
	wire [2:0] mode; // Operating mode
	wire req_oe, foff_oe, chain_oe, good, rst_n; // Pin drives, status
	wire [3:0] slot_o; // Scan slot shown
	wire [9:0] cres; // Single conversion result
	wire cdone, alarm_n; // Conversion done, alarm
	logic creq = 1'b0; // Single conversion request
	logic [3:0] on_prev = 4'h0; // Enables seen last cycle
	logic [15:0] ord = 16'h0; // Channels in switching order
	int err_count = 0, n_compared = 0; // Mismatches, compares
	always #5 clk = ~clk;
	// Log each enable change as a channel digit
	always @(posedge clk)
	begin
		on_prev <= ~(en ^ pol);
		for (int g = 0; g < 4; g++)
			if (on_prev[g] != ~(en[g] ^ pol[g]))
				ord = {ord[11:0], 4'(g)};
	end
	ssmc_conv_model u_conv (.clk_i(clk), .en_i(en), .pol_i(pol), .thr_o(thr), .off_o(off));
	// lone device, chain follows own drive
	ssmc_top DUT
	(
		.CLOCK_I(clk), .NRST_I(nrst), .POWER_UP_REQUEST_I(req_host & ~req_oe),
		.POWER_UP_REQUEST_O(), .POWER_UP_REQUEST_OE_O(req_oe),
		.FORCED_OFF_LINE_N_I(foff_host & ~foff_oe), .FORCED_OFF_LINE_N_O(),
		.FORCED_OFF_LINE_N_OE_O(foff_oe), .CHAIN_LINE_I(~chain_oe), .CHAIN_LINE_O(),
		.CHAIN_LINE_OE_O(chain_oe), .MANUAL_RESET_N_I(mr_n), .SEQ_ORDER_I(order),
		.ENABLE_POL_I(pol), .CH_USED_I(used), .TERM_TIMEOUT_I(16'h00ff),
		.TERM_ON_EN_I(term_en), .TERM_OFF_EN_I(term_en), .REGULATION_EN_I(reg_en),
		.RESET_TIMEOUT_SEL_I(2'h0), .UV1_I(flt), .UV2_I(flt), .OV1_I(flt), .OV2_I(flt),
		.SEQ_THR_I(thr), .SUPPLY_OFF_I(off), .TRIG_RESET_I(trg), .TRIG_GOOD_I(trg),
		.TRIG_ALARM_I(trg), .TRIG_POFF_I(trg), .TRIG_FOFF_I(trg), .MARGIN_CMD_I(cmd[0]),
		.MARGIN_EXIT_I(cmd[1]), .MARGIN_SET_I(mset), .POWER_OFF_CMD_I(cmd[2]),
		.CONV_SEL_I(4'h0), .CONV_REQ_I(creq), .CONV_DATA_I(10'h2a5),
		.CONVERTER_ENABLE_O(en), .SCAN_SLOT_O(slot_o), .REG_ACTIVE_O(reg_act),
		.REG_TARGET_O(tgt), .SUPPLIES_GOOD_O(good), .RESET_N_O(rst_n), .ALARM_N_O(alarm_n),
		.MODE_O(mode), .CONV_RESULT_O(cres), .CONV_DONE_O(cdone)
	);
	// Compare one value, count and report
	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		n_compared++;
		if (got !== exp)
		begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic end_of_test;
		if (err_count == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// Let edges pass, then settle
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// One-cycle host command pulse
	task automatic pulse(input logic [2:0] b);
		@(posedge clk) cmd <= b;
		@(posedge clk) cmd <= 3'h0;
		tick(3);
	endtask
	// Bounded wait for a mode
	task automatic wait_mode(input logic [2:0] m, input int lim);
		int i;
		i = 0;
		while (mode !== m && i < lim)
		begin
			tick(1);
			i++;
		end
		chk("mode", 16'(m), 16'(mode));
	endtask
	initial
	begin
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		tick(4);
		chk("enable_idle", {12'h0, ~pol}, 16'(en));
		pulse(3'h1);
		chk("margin_in_idle", 16'(`SSMC_MD_IDLE), 16'(mode));
		@(posedge clk) req_host <= 1'b1;
		wait_mode(`SSMC_MD_PON, 20);
		chk("good_reset_pon", 16'h0, {14'h0, good, rst_n});
		wait_mode(`SSMC_MD_MON, 60000);
		chk("order_on", 16'h3201, ord);
		tick(2);
		chk("regulating", 16'hf, 16'(reg_act));
		chk("good_mon", 16'h1, 16'(good));
		chk("alarm_clear", 16'h1, 16'(alarm_n));
		@(posedge clk) creq <= 1'b1;
		@(posedge clk) creq <= 1'b0;
		tick(1);
		chk("conv_pending", 16'h0, 16'(cdone));
		for (int i = 0; i < 23000 && cdone !== 1'b1; i++)
			tick(1);
		chk("conv_result", 16'h2a5, 16'(cres));
		chk("reset_held", 16'h0, 16'(rst_n));
		tick(2);
		chk("scan_slot", 16'h1, 16'(slot_o));
		for (int i = 0; i < 66000 && rst_n !== 1'b1; i++)
			tick(1);
		chk("reset_released", 16'h1, 16'(rst_n));
		@(posedge clk) mset <= 8'h19;
		pulse(3'h1);
		chk("mode_margin", 16'(`SSMC_MD_MARG), 16'(mode));
		chk("good_reset_marg", 16'h3, {14'h0, good, rst_n});
		chk("targets", 16'h19, 16'(tgt));
		@(posedge clk) mset <= 8'h26;
		tick(3);
		chk("targets", 16'h26, 16'(tgt));
		pulse(3'h4);
		chk("poff_in_margin", 16'(`SSMC_MD_MARG), 16'(mode));
		pulse(3'h2);
		wait_mode(`SSMC_MD_MON, 10);
		ord = 16'h0;
		pulse(3'h4);
		wait_mode(`SSMC_MD_IDLE, 2000);
		chk("order_off", 16'h1023, ord);
		@(posedge clk) req_host <= 1'b0;
		tick(8);
		@(posedge clk) req_host <= 1'b1;
		wait_mode(`SSMC_MD_PON, 20);
		@(posedge clk) foff_host <= 1'b0;
		wait_mode(`SSMC_MD_IDLE, 20);
		tick(6);
		chk("enable_forced", {12'h0, ~pol}, 16'(en));
		chk("request_pulled", 16'h1, 16'(req_oe));
		@(posedge clk) flt <= 9'h1ff;
		for (int i = 0; i < 23000 && alarm_n !== 1'b0; i++)
			tick(1);
		chk("alarm_fault", 16'h0, 16'(alarm_n));
		end_of_test();
	end
	// Cut a hang short
	initial
	begin
		repeat (90000) @(posedge clk);
		err_count++;
		end_of_test();
	end
endmodule
`default_nettype wire
